// ---- hdl/wdc_regs.svh ----
`ifndef WDC_REGS_SVH
`define WDC_REGS_SVH

// ----------------------------------------
// Register address and fields
// ----------------------------------------
`define WDC_SFR_ADDR 8'h97
`define WDC_CODE_MSB 2
`define WDC_ACTIVE_BIT 4
`define WDC_CMD_BIT 7
`define WDC_CODE_RST 3'h7

// ----------------------------------------
// Command codes
// ----------------------------------------
`define WDC_CMD_ENABLE 8'ha5
`define WDC_CMD_DIS_FIRST 8'hde
`define WDC_CMD_DIS_SECOND 8'had
`define WDC_CMD_LOCK 8'hff

// ----------------------------------------
// Timing
// ----------------------------------------
`define WDC_DIS_WINDOW_CYC 3'h4
`define WDC_EXP_OFFSET 5'h06
`define WDC_CNT_W 21

`endif

// ---- hdl/wdc_pkg.sv ----
package wdc_pkg;

	// ----------------------------------------
	// Decoded write commands
	// ----------------------------------------
	typedef enum logic [2:0] {
		WDC_CMD_NONE,
		WDC_CMD_INTERVAL,
		WDC_CMD_RELOAD,
		WDC_CMD_DIS_ARM,
		WDC_CMD_DIS_FIRE,
		WDC_CMD_LOCKOUT,
		WDC_CMD_OTHER
	} wdc_cmd_type;

	// ----------------------------------------
	// Run state of the watchdog_timer
	// ----------------------------------------
	typedef enum logic [1:0] {
		WDC_RUNNING,
		WDC_STOPPED,
		WDC_EXPIRED
	} wdc_state_type;

endpackage

// ---- hdl/wdc_watchdog.sv ----
`timescale 1ns/10ps
`include "wdc_regs.svh"

// What this block does
// RL1 - Read returns interval code in bits 2:0
// RL2 - Read bit 4 shows watchdog running
// RL3 - Write with bit 7 clear sets interval
// RL4 - Write 0xA5 enables and clears counter
// RL5 - 0xDE then 0xAD within 4 clocks disables
// RL6 - Write 0xFF locks out disabling until reset
// RL7 - Counter ticks per divided oscillator; limit resets
// RL8 - Timeout is 4 to power code plus 3
// RL9 - Reset: enabled, counter clear, interval maximum
// RL10 - Disable freezes counter; comparator stays active
// RL11 - Other command bytes only cancel a pending disable

module wdc_watchdog
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Special function register access
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// Divided low_freq_oscillator tick, one cycle per period
	input wire logic low_freq_oscillator_tick,
	// Status towards the system
	output logic low_freq_oscillator_force_on,
	output logic watchdog_reset_req
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	wdc_pkg::wdc_state_type state_ff;
	wdc_pkg::wdc_state_type nxt_state;
	logic [2:0] code_ff;
	logic [2:0] nxt_code;
	logic lock_ff;
	logic nxt_lock;
	logic [2:0] dis_win_ff;
	logic [2:0] nxt_dis_win;
	logic [`WDC_CNT_W-1:0] cnt_ff;
	logic [`WDC_CNT_W-1:0] nxt_cnt;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	logic force_on_ff;
	logic reset_req_ff;

	// ----------------------------------------
	// Address decode and command decode
	// ----------------------------------------
	wire logic reg_hit = (sfr_addr == `WDC_SFR_ADDR);
	wire logic wr_hit = sfr_wr && reg_hit;
	wire logic rd_hit = sfr_rd && reg_hit;
	wire logic is_cmd = sfr_wdata[`WDC_CMD_BIT];
	wire logic is_enable = (sfr_wdata == `WDC_CMD_ENABLE);
	wire logic is_dis_first = (sfr_wdata == `WDC_CMD_DIS_FIRST);
	wire logic is_dis_second = (sfr_wdata == `WDC_CMD_DIS_SECOND);
	wire logic is_lock = (sfr_wdata == `WDC_CMD_LOCK);
	wire wdc_pkg::wdc_cmd_type cmd =
		!wr_hit ? wdc_pkg::WDC_CMD_NONE :
		!is_cmd ? wdc_pkg::WDC_CMD_INTERVAL : // [RL3]
		is_enable ? wdc_pkg::WDC_CMD_RELOAD :
		is_dis_first ? wdc_pkg::WDC_CMD_DIS_ARM :
		is_dis_second ? wdc_pkg::WDC_CMD_DIS_FIRE :
		is_lock ? wdc_pkg::WDC_CMD_LOCKOUT :
		wdc_pkg::WDC_CMD_OTHER; // [RL11]

	// Second disable byte counts only inside the window and without the lock
	wire logic dis_ok = (cmd == wdc_pkg::WDC_CMD_DIS_FIRE) && (dis_win_ff != 3'h0) && !lock_ff; // [RL5] [RL6]

	// ----------------------------------------
	// Timeout limit: 4^(code+3) ticks
	// ----------------------------------------
	wire logic [4:0] limit_shift = {1'b0, code_ff, 1'b0} + `WDC_EXP_OFFSET; // [RL8]
	wire logic [`WDC_CNT_W-1:0] limit = {{(`WDC_CNT_W-1){1'b0}}, 1'b1} << limit_shift; // [RL8]
	// Comparator runs in every state, so a frozen count can still expire
	wire logic expire = (cnt_ff >= limit); // [RL10] [RL7]
	wire logic running = (state_ff == wdc_pkg::WDC_RUNNING);

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb
	begin
		nxt_state = state_ff;
		nxt_code = code_ff;
		nxt_lock = lock_ff;
		nxt_cnt = cnt_ff;
		nxt_dis_win = (dis_win_ff != 3'h0) ? dis_win_ff - 3'h1 : 3'h0;
		// Count only while running
		if (running && low_freq_oscillator_tick)
		begin
			nxt_cnt = cnt_ff + {{(`WDC_CNT_W-1){1'b0}}, 1'b1}; // [RL7]
		end
		unique case (cmd)
			wdc_pkg::WDC_CMD_NONE:
			begin
			end
			wdc_pkg::WDC_CMD_INTERVAL:
			begin
				nxt_code = sfr_wdata[`WDC_CODE_MSB:0]; // [RL3]
				nxt_dis_win = 3'h0;
			end
			wdc_pkg::WDC_CMD_RELOAD:
			begin
				nxt_cnt = '0; // [RL4]
				nxt_dis_win = 3'h0;
				if (state_ff == wdc_pkg::WDC_STOPPED)
				begin
					nxt_state = wdc_pkg::WDC_RUNNING; // [RL4]
				end
			end
			wdc_pkg::WDC_CMD_DIS_ARM:
			begin
				nxt_dis_win = `WDC_DIS_WINDOW_CYC; // [RL5]
			end
			wdc_pkg::WDC_CMD_DIS_FIRE:
			begin
				nxt_dis_win = 3'h0;
				// Counter keeps its value on disable
				if (dis_ok && running)
				begin
					nxt_state = wdc_pkg::WDC_STOPPED; // [RL5] [RL10]
				end
			end
			wdc_pkg::WDC_CMD_LOCKOUT:
			begin
				nxt_lock = 1'b1; // [RL6]
				nxt_dis_win = 3'h0;
			end
			wdc_pkg::WDC_CMD_OTHER:
			begin
				nxt_dis_win = 3'h0; // [RL11]
			end
		endcase
		// Expiry overrides the state and the counter until the system reset arrives
		if (expire || state_ff == wdc_pkg::WDC_EXPIRED)
		begin
			nxt_state = wdc_pkg::WDC_EXPIRED; // [RL7]
			nxt_cnt = cnt_ff;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_comb
	begin
		nxt_rdata = rdata_ff;
		if (rd_hit)
		begin
			nxt_rdata = 8'h00;
			nxt_rdata[`WDC_CODE_MSB:0] = code_ff; // [RL1]
			nxt_rdata[`WDC_ACTIVE_BIT] = running; // [RL2]
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_ff <= wdc_pkg::WDC_RUNNING; // [RL9]
			force_on_ff <= 1'b1;
			reset_req_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			force_on_ff <= (nxt_state == wdc_pkg::WDC_RUNNING);
			reset_req_ff <= (nxt_state == wdc_pkg::WDC_EXPIRED); // [RL7]
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			code_ff <= `WDC_CODE_RST; // [RL9]
			lock_ff <= 1'b0; // [RL6]
		end
		else
		begin
			code_ff <= nxt_code;
			lock_ff <= nxt_lock;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cnt_ff <= '0; // [RL9]
			dis_win_ff <= 3'h0;
		end
		else
		begin
			cnt_ff <= nxt_cnt;
			dis_win_ff <= nxt_dis_win;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rdata_ff <= 8'h00;
		end
		else
		begin
			rdata_ff <= nxt_rdata;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign sfr_rdata = rdata_ff;
	assign low_freq_oscillator_force_on = force_on_ff;
	assign watchdog_reset_req = reset_req_ff;

endmodule // wdc_watchdog

// ---- testbench/wdc_watchdog_asserts.sv ----
`timescale 1ns/10ps
module wdc_watchdog_asserts
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register access
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	// Status
	input wire logic low_freq_oscillator_force_on,
	input wire logic watchdog_reset_req
);
	logic lock_ff;
	wire logic nxt_lock;
	wire logic fon = low_freq_oscillator_force_on;
	wire logic wh = sfr_wr && sfr_addr == 8'h97;
	wire logic rh = sfr_rd && sfr_addr == 8'h97;
	assign nxt_lock = rst_n && (lock_ff || (wh && sfr_wdata == 8'hff));
	always_ff @(posedge clk) lock_ff <= nxt_lock;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_rst; disable iff (1'b0) !rst_n |=> sfr_rdata == 8'h00 && fon && !watchdog_reset_req; endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
	property p_code; wh && !sfr_wdata[7] ##1 rh |=> sfr_rdata[2:0] == $past(sfr_wdata[2:0], 2); endproperty
	a_code: assert property (p_code) else $error("bad code");
	property p_run;
		rh && !$past(sfr_wr) && !$past(sfr_wr, 2) && !watchdog_reset_req |=> sfr_rdata[4] == $past(fon);
	endproperty
	a_run: assert property (p_run) else $error("bad run bit");
	property p_en; wh && sfr_wdata == 8'ha5 && !watchdog_reset_req |-> ##[1:3] fon; endproperty
	a_en: assert property (p_en) else $error("not enabled");
	property p_dis; wh && sfr_wdata == 8'hde ##1 wh && sfr_wdata == 8'had && !lock_ff |-> ##[1:3] !fon; endproperty
	a_dis: assert property (p_dis) else $error("not disabled");
	property p_lock; lock_ff && fon && wh && sfr_wdata == 8'had |=> fon [*3]; endproperty
	a_lock: assert property (p_lock) else $error("lock ignored");
	property p_hold; !rh |=> $stable(sfr_rdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_req; watchdog_reset_req |=> watchdog_reset_req; endproperty
	a_req: assert property (p_req) else $error("request dropped");
endmodule // wdc_watchdog_asserts
bind wdc_watchdog wdc_watchdog_asserts wdc_watchdog_asserts_inst (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
	.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
	.low_freq_oscillator_force_on(low_freq_oscillator_force_on), .watchdog_reset_req(watchdog_reset_req));

// ---- testbench/test_watchdog_command_register.sv ----
`timescale 1ns/10ps
module test_watchdog_command_register;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h97;
	logic wen = 1'b0;
	logic ren = 1'b0;
	logic tck = 1'b0;
	logic [7:0] wdat = 8'h00;
	logic [7:0] rdat;
	logic fon;
	logic req;
	int fails = 0;
	int checks = 0;
	always #4 clk = ~clk;
	wdc_watchdog wdc_watchdog_inst (.clk(clk), .rst_n(rst_n), .sfr_addr(addr), .sfr_wr(wen), .sfr_rd(ren),
		.sfr_wdata(wdat), .sfr_rdata(rdat), .low_freq_oscillator_tick(tck),
		.low_freq_oscillator_force_on(fon), .watchdog_reset_req(req));
	task summarize;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e)
		begin
			fails++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask
	task drv(input logic w, input logic r, input logic t, input logic [7:0] d);
		@(posedge clk);
		#1;
		wen = w;
		ren = r;
		tck = t;
		wdat = d;
	endtask
	task wr(input logic [7:0] d);
		drv(1'b1, 1'b0, 1'b0, d);
	endtask
	task idle(input int n);
		repeat (n) drv(1'b0, 1'b0, 1'b0, 8'h00);
	endtask
	task rd(input logic [7:0] e);
		drv(1'b0, 1'b1, 1'b0, 8'h00);
		idle(1);
		chk("read", rdat, e);
	endtask
	task ticks(input int n);
		repeat (n) drv(1'b0, 1'b0, 1'b1, 8'h00);
		idle(3);
	endtask
	task restart;
		rst_n = 1'b0;
		idle(3);
		rst_n = 1'b1;
	endtask
	initial
	begin
		#20000;
		fails++;
		summarize;
	end
	initial
	begin
		restart;
		rd(8'h17);
		wr(8'h02);
		rd(8'h12);
		wr(8'hc5);
		rd(8'h12);
		addr = 8'h98;
		wr(8'hde);
		wr(8'had);
		rd(8'h12);
		addr = 8'h97;
		rd(8'h12);
		wr(8'hde);
		wr(8'had);
		rd(8'h02);
		wr(8'ha5);
		rd(8'h12);
		wr(8'hde);
		idle(4);
		wr(8'had);
		rd(8'h12);
		wr(8'hde);
		idle(3);
		wr(8'had);
		rd(8'h02);
		wr(8'ha5);
		wr(8'hff);
		wr(8'hde);
		wr(8'had);
		rd(8'h12);
		chk("force_on", {7'h00, fon}, 8'h01);
		$display("test 1 done");
		restart;
		wr(8'hde);
		wr(8'had);
		rd(8'h07);
		chk("force_on", {7'h00, fon}, 8'h00);
		wr(8'h00);
		wr(8'ha5);
		ticks(63);
		chk("req", {7'h00, req}, 8'h00);
		ticks(1);
		chk("req", {7'h00, req}, 8'h01);
		restart;
		rd(8'h17);
		wr(8'h01);
		wr(8'ha5);
		ticks(100);
		wr(8'ha5);
		ticks(200);
		chk("req", {7'h00, req}, 8'h00);
		wr(8'hde);
		wr(8'had);
		ticks(50);
		chk("req", {7'h00, req}, 8'h00);
		wr(8'h00);
		idle(3);
		chk("req", {7'h00, req}, 8'h01);
		$display("test 2 done");
		summarize;
	end
endmodule // test_watchdog_command_register
